/* logic/pcrc_top.sv */
`timescale 1ns/1ps
// How it works
// - Vector area comes from bank zero or SRAM
// - Idle halts processor until reset or interrupt
// - Idle keeps peripheral clocks; interrupt resumes execution
// - Idle gates processor, memory and bus clocks
// - Power-down stops oscillator and every internal clock
// - Power-down retains all processor, register, SRAM state
// - Power-down holds output pins at entry level
// - Power-down ends only by reset or clockless wake
// - Each peripheral clock switchable off individually
// - Peripheral clock is full, half or quarter rate
// - Quarter rate after reset; setting on peripheral bus
// - PLL kept running through Idle if it ran
// - Processor runs on oscillator unless PLL running and connected
// - Every power-down wake passes the wake timer
// - Enabled external interrupts wake from power-down
module pcrc_top #(
  parameter int NUM_PERIPH = pcrc_pkg::PCRC_NUM_PERIPH,
  parameter int NUM_WAKE = pcrc_pkg::PCRC_NUM_WAKE,
  parameter int WAKE_CYCLES = pcrc_pkg::PCRC_WAKE_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic remap_sram_i,
  input wire logic idle_req_i,
  input wire logic pdown_req_i,
  input wire logic irq_i,
  input wire logic [NUM_WAKE-1:0] ext_irq_i,
  input wire logic [NUM_WAKE-1:0] ext_wake_en_i,
  input wire logic osc_ready_i,
  input wire logic pll_on_i,
  input wire logic pll_connect_i,
  input wire logic [NUM_PERIPH-1:0] periph_pwr_i,
  input wire logic [1:0] apb_div_sel_i,
  input wire logic apb_div_wr_i,
  output logic vec_from_sram_o,
  output logic cpu_clk_en_o,
  output logic mem_clk_en_o,
  output logic bus_clk_en_o,
  output logic pclk_en_o,
  output logic [NUM_PERIPH-1:0] periph_clk_en_o,
  output logic osc_en_o,
  output logic pll_en_o,
  output logic clk_src_pll_o,
  output logic pin_hold_o,
  output logic state_retain_o,
  output logic [1:0] apb_div_now_o,
  output logic [1:0] mode_o
);

  // The wake timer is sized from the settle count so that a slower
  // oscillator only needs a new parameter value, not new logic
  localparam int WCW = $clog2(WAKE_CYCLES + 1); // Wake counter width
  // Last count of the settle period; the timer rests here until the
  // oscillator reports ready
  localparam logic [WCW-1:0] WAKE_LAST = WCW'(WAKE_CYCLES - 1);

  // The divider sits in its own module; the sequencer steers it and
  // reads back its tick and the ratio that it has adopted
  pcrc_div_if div_if (); // Sequencer to divider link

  // Sequencer state
  pcrc_pkg::pcrc_mode_t mode_q; // Current power mode
  pcrc_pkg::pcrc_mode_t mode_d; // Mode for the next cycle
  logic [WCW-1:0] wake_cnt_q; // Cycles spent waking
  logic [WCW-1:0] wake_cnt_d; // Next wake count
  // Settings kept across power modes
  logic [1:0] div_sel_q; // Divider setting register
  logic pll_was_on_q; // PLL state latched on Idle entry
  logic pll_was_on_d; // Next latched PLL state
  // Output registers; every output except mode_o comes straight from one of these
  logic vec_sram_q; // Vectors taken from SRAM
  logic cpu_en_q; // Processor, memory and bus clock enable
  logic pclk_q; // Peripheral clock enable pulse
  logic [NUM_PERIPH-1:0] periph_q; // Gated peripheral enables
  logic osc_q; // Oscillator enable
  logic pll_q; // PLL enable
  logic src_pll_q; // Processor clock taken from the PLL
  logic hold_q; // Output pins frozen
  logic retain_q; // State retention request
  logic [1:0] div_now_q; // Ratio in force, as reported
  // Decodes
  logic wake_hit; // Enabled clockless wake source
  logic wake_done; // Timer expired and oscillator up
  logic is_run; // Full operation
  logic is_idle; // Processor halted, peripherals run
  logic pd_like; // Power-down or waking from it
  logic pd_next; // Power-down or waking from the next cycle on
  logic div_wr_ok; // Setting write lands on a peripheral cycle

  // Mode decode shared by the output logic
  // Waking counts as powered down until the timer releases it
  assign is_run = (mode_q == pcrc_pkg::PCRC_RUN);
  assign is_idle = (mode_q == pcrc_pkg::PCRC_IDLE);
  assign pd_like = (mode_q == pcrc_pkg::PCRC_PDOWN) ||
                   (mode_q == pcrc_pkg::PCRC_WAKE);
  // Same decode one cycle ahead, so clocks stop on the entry edge
  assign pd_next = (mode_d == pcrc_pkg::PCRC_PDOWN) ||
                   (mode_d == pcrc_pkg::PCRC_WAKE);

  // Only enabled external inputs may end power-down
  assign wake_hit = |(ext_irq_i & ext_wake_en_i);
  // Resume needs both the settle count and a running oscillator
  assign wake_done = (wake_cnt_q == WAKE_LAST) && osc_ready_i;

  // The divider setting sits on the peripheral bus
  // and is written only on the cycle before a peripheral pulse
  assign div_wr_ok = apb_div_wr_i && div_if.tick_next;

  // Divider steering: it runs except in power-down and while waking
  // It holds its count while stopped and carries on after the wake
  assign div_if.ratio_sel = div_sel_q;
  assign div_if.run = !pd_like;

  // Power mode sequencer. Requests are honoured only in Run; an
  // interrupt only ends Idle, and only an enabled external input
  // ends power-down, after which the wake timer must run out
  // before the processor may execute again
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      pcrc_pkg::PCRC_RUN: begin
        // Power-down takes priority over Idle
        if (pdown_req_i) begin
          mode_d = pcrc_pkg::PCRC_PDOWN;
        end else if (idle_req_i) begin
          mode_d = pcrc_pkg::PCRC_IDLE;
        end
      end
      pcrc_pkg::PCRC_IDLE: begin
        // Any interrupt resumes the processor
        // Peripherals keep running here and may raise it
        if (irq_i) begin
          mode_d = pcrc_pkg::PCRC_RUN;
        end
      end
      pcrc_pkg::PCRC_PDOWN: begin
        // Ordinary interrupts are ignored here
        // Only sources that work without a clock are seen
        if (wake_hit) begin
          mode_d = pcrc_pkg::PCRC_WAKE;
        end
      end
      pcrc_pkg::PCRC_WAKE: begin
        // Execution waits for the wake timer
        // The oscillator must also report ready
        if (wake_done) begin
          mode_d = pcrc_pkg::PCRC_RUN;
        end
      end
      default: begin
        // No other code exists; fall back to Run for safety
        mode_d = pcrc_pkg::PCRC_RUN;
      end
    endcase
  end

  // Wake timer counts only while waking and saturates
  // It restarts from zero on every entry, so a second wake
  // cannot inherit time from an earlier one
  assign wake_cnt_d = (mode_q != pcrc_pkg::PCRC_WAKE) ? '0 :
                      (wake_cnt_q == WAKE_LAST) ? wake_cnt_q :
                      wake_cnt_q + WCW'(1);

  // Remember whether the PLL ran at Idle entry
  // The peripheral divider hangs off the PLL output, so the PLL
  // must not drop in Idle even if its request goes away
  assign pll_was_on_d = (is_run && idle_req_i && !pdown_req_i) ?
                        pll_on_i : pll_was_on_q;

  // Sequencer state
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= pcrc_pkg::PCRC_RUN;
      wake_cnt_q <= '0;
      pll_was_on_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      wake_cnt_q <= wake_cnt_d;
      pll_was_on_q <= pll_was_on_d;
    end
  end

  // Divider setting register, quarter rate from reset
  // A write is only taken on a peripheral cycle; others are lost
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_sel_q <= pcrc_pkg::PCRC_DIV_QUARTER;
    end else if (div_wr_ok) begin
      div_sel_q <= apb_div_sel_i;
    end
  end

  // Vector source follows the remap selection
  // Frozen while powered down so the map is unchanged on resume
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vec_sram_q <= 1'b0;
    end else if (!pd_like) begin
      vec_sram_q <= remap_sram_i;
    end
  end

  // Processor, memory and bus share one gate, off in Idle
  // Taken from the next mode so the gate closes on the entry edge
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_en_q <= 1'b1;
    end else begin
      cpu_en_q <= (mode_d == pcrc_pkg::PCRC_RUN);
    end
  end

  // Peripheral clock enable, alive in Run and Idle
  // No pulse may escape on the edge that enters power-down
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pclk_q <= 1'b0;
    end else begin
      pclk_q <= div_if.tick_next && !pd_next;
    end
  end

  // Per-peripheral clock gates
  // A switched-off peripheral keeps its state; it only loses clocks
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          periph_q[gi] <= 1'b0;
        end else begin
          periph_q[gi] <= div_if.tick_next && periph_pwr_i[gi] &&
                          !pd_next;
        end
      end
    end
  endgenerate

  // Oscillator, PLL and clock source control
  // Stop decisions use the next mode so nothing runs in power-down
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_q <= 1'b1;
      pll_q <= 1'b0;
      src_pll_q <= 1'b0;
    end else begin
      // Oscillator off in power-down, restarted on wake
      osc_q <= (mode_d != pcrc_pkg::PCRC_PDOWN);
      // PLL held on through Idle if it was running
      pll_q <= is_idle ? pll_was_on_q : (pll_on_i && !pd_next);
      // PLL feeds the processor only when running and connected
      src_pll_q <= pll_on_i && pll_connect_i && !pd_next;
    end
  end

  // Pin hold and state retention during power-down
  // Both rise on the entry edge and fall on the edge that resumes Run
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_q <= 1'b0;
      retain_q <= 1'b0;
    end else begin
      hold_q <= pd_next;
      retain_q <= pd_next;
    end
  end

  // Status copies of ratio in force
  // Lags the divider by one cycle; the mode-driven outputs other than vec_from_sram_o and pll_en_o are taken from the next mode and do not lag
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_now_q <= pcrc_pkg::PCRC_DIV_QUARTER;
    end else begin
      div_now_q <= div_if.ratio_now;
    end
  end

  // Peripheral clock divider
  pcrc_apb_div u_div (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .dv(div_if)
  );

  // Port drivers; each output is a plain copy of its register
  // Processor, memory and internal buses share one gate
  assign vec_from_sram_o = vec_sram_q;
  assign cpu_clk_en_o = cpu_en_q;
  assign mem_clk_en_o = cpu_en_q;
  assign bus_clk_en_o = cpu_en_q;
  assign pclk_en_o = pclk_q;
  assign periph_clk_en_o = periph_q;
  assign osc_en_o = osc_q;
  assign pll_en_o = pll_q;
  assign clk_src_pll_o = src_pll_q;
  assign pin_hold_o = hold_q;
  assign state_retain_o = retain_q;
  assign apb_div_now_o = div_now_q;
  assign mode_o = mode_q;

endmodule

/* logic/pcrc_pkg.sv */
package pcrc_pkg;

  // Operating modes of the power sequencer
  typedef enum logic [1:0] {
    PCRC_RUN   = 2'h0,
    PCRC_IDLE  = 2'h1,
    PCRC_PDOWN = 2'h2,
    PCRC_WAKE  = 2'h3
  } pcrc_mode_t;

  // Peripheral divider ratio codes; zero is the reset ratio
  localparam logic [1:0] PCRC_DIV_QUARTER = 2'h0;
  localparam logic [1:0] PCRC_DIV_FULL = 2'h1;
  localparam logic [1:0] PCRC_DIV_HALF = 2'h2;

  // Counter reloads for each ratio (period minus one)
  localparam logic [1:0] PCRC_RLD_FULL = 2'h0;
  localparam logic [1:0] PCRC_RLD_HALF = 2'h1;
  localparam logic [1:0] PCRC_RLD_QUARTER = 2'h3;

  // Processor clock rate and default oscillator settle time
  localparam int PCRC_CLK_MHZ = 100;
  localparam int PCRC_WAKE_US = 100;
  localparam int PCRC_WAKE_CYCLES = PCRC_WAKE_US * PCRC_CLK_MHZ;

  // Default peripheral and wake source counts
  localparam int PCRC_NUM_PERIPH = 16;
  localparam int PCRC_NUM_WAKE = 4;

endpackage

/* logic/pcrc_div_if.sv */
`timescale 1ns/1ps
// Link between the sequencer and the peripheral clock divider
interface pcrc_div_if;
  logic [1:0] ratio_sel; // Requested ratio code
  logic run; // Divider may count
  logic tick_next; // Next-cycle peripheral clock enable
  logic [1:0] ratio_now; // Ratio currently in force

  modport ctrl (output ratio_sel, output run,
                input tick_next, input ratio_now);
  modport div (input ratio_sel, input run,
               output tick_next, output ratio_now);
endinterface

/* logic/pcrc_apb_div.sv */
`timescale 1ns/1ps
// Peripheral clock divider producing a one-cycle enable per period
module pcrc_apb_div (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  pcrc_div_if.div dv
);

  logic [1:0] cnt_q; // Cycles left in the current period
  logic [1:0] cnt_d;
  logic [1:0] ratio_q; // Ratio in force
  logic [1:0] ratio_d;
  logic at_edge; // Period boundary

  // Reload value for a ratio code
  function automatic logic [1:0] reload_of(input logic [1:0] code);
    if (code == pcrc_pkg::PCRC_DIV_FULL) begin
      reload_of = pcrc_pkg::PCRC_RLD_FULL;
    end else if (code == pcrc_pkg::PCRC_DIV_HALF) begin
      reload_of = pcrc_pkg::PCRC_RLD_HALF;
    end else begin
      reload_of = pcrc_pkg::PCRC_RLD_QUARTER;
    end
  endfunction

  assign at_edge = dv.run && (cnt_q == 2'h0);
  // New ratio is adopted only at a boundary, never mid-period
  assign ratio_d = at_edge ? dv.ratio_sel : ratio_q;
  assign cnt_d = !dv.run ? cnt_q :
                 at_edge ? reload_of(dv.ratio_sel) : cnt_q - 2'h1;
  assign dv.tick_next = at_edge;
  assign dv.ratio_now = ratio_q;

  // Counter and ratio state; quarter rate after reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
      ratio_q <= pcrc_pkg::PCRC_DIV_QUARTER;
    end else begin
      cnt_q <= cnt_d;
      ratio_q <= ratio_d;
    end
  end

endmodule

/* dv/pcrc_osc_model.sv */
`timescale 1ns/1ps
// Oscillator stand-in: ready at once after reset, and DLY cycles of enable after each restart
module pcrc_osc_model #(
  parameter int DLY = 20
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic osc_en_i,
  output logic osc_ready_o
);
  int cnt_q; // Cycles since the oscillator was started
  // Restart the settle count whenever it is shut down
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_q <= DLY;
    else if (!osc_en_i) cnt_q <= 0;
    else if (cnt_q < DLY) cnt_q <= cnt_q + 1;
  end
  // No output while stopped or still settling
  assign osc_ready_o = osc_en_i && (cnt_q >= DLY);
endmodule

/* dv/pcrc_top_chk.sv */
`timescale 1ns/1ps
// Port-level checks of the power and clock sequencer
module pcrc_top_chk #(
  parameter int NUM_PERIPH = 16,
  parameter int NUM_WAKE = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic idle_req_i,
  input wire logic pdown_req_i,
  input wire logic irq_i,
  input wire logic [NUM_WAKE-1:0] ext_irq_i,
  input wire logic [NUM_WAKE-1:0] ext_wake_en_i,
  input wire logic [NUM_PERIPH-1:0] periph_pwr_i,
  input wire logic cpu_clk_en_o,
  input wire logic pclk_en_o,
  input wire logic [NUM_PERIPH-1:0] periph_clk_en_o,
  input wire logic osc_en_o,
  input wire logic pll_en_o,
  input wire logic pin_hold_o,
  input wire logic state_retain_o,
  input wire logic [1:0] apb_div_now_o,
  input wire logic [1:0] mode_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Idle request accepted from run
  sequence s_idle_go;
    mode_o == 2'h0 && idle_req_i && !pdown_req_i;
  endsequence
  // Three quiet cycles after a quarter-rate pulse
  sequence s_gap;
    (!pclk_en_o || apb_div_now_o != 2'h0) [*3];
  endsequence
  a_idle_entry: assert property (
    s_idle_go |=> mode_o == 2'h1 && !cpu_clk_en_o)
    else $error("idle entry wrong");
  a_idle_exit: assert property (
    mode_o == 2'h1 && irq_i |=> mode_o == 2'h0 && cpu_clk_en_o)
    else $error("idle exit wrong");
  a_pdown_hold: assert property (
    mode_o == 2'h2 |-> !osc_en_o && !pclk_en_o && pin_hold_o &&
    state_retain_o && !cpu_clk_en_o)
    else $error("power-down outputs wrong");
  a_pdown_stay: assert property (
    mode_o == 2'h2 && !(|(ext_irq_i & ext_wake_en_i)) |=> mode_o == 2'h2)
    else $error("power-down left early");
  a_wake_entry: assert property (
    mode_o == 2'h2 && |(ext_irq_i & ext_wake_en_i) |=> mode_o == 2'h3)
    else $error("wake not started");
  a_wake_min: assert property (
    $rose(mode_o == 2'h3) |-> (mode_o == 2'h3) [*4])
    else $error("wake timer too short");
  a_periph_gate: assert property (
    periph_clk_en_o == ({NUM_PERIPH{pclk_en_o}} & $past(periph_pwr_i)))
    else $error("peripheral gate wrong");
  a_quarter_gap: assert property (
    pclk_en_o && apb_div_now_o == 2'h0 |=> s_gap)
    else $error("quarter spacing wrong");
  a_pll_idle: assert property (
    mode_o == 2'h1 && $past(mode_o) == 2'h1 |-> $stable(pll_en_o))
    else $error("pll changed in idle");
endmodule

/* dv/test_pcrc_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module test_pcrc_top;
  logic clk_sys_i, rst_n_i, remap_sram_i, idle_req_i, pdown_req_i, irq_i;
  logic osc_ready_i, pll_on_i, pll_connect_i, apb_div_wr_i;
  logic [3:0] ext_irq_i, ext_wake_en_i;
  logic [15:0] periph_pwr_i, periph_clk_en_o;
  logic [1:0] apb_div_sel_i, apb_div_now_o, mode_o;
  logic vec_from_sram_o, cpu_clk_en_o, mem_clk_en_o, bus_clk_en_o, pclk_en_o;
  logic osc_en_o, pll_en_o, clk_src_pll_o, pin_hold_o, state_retain_o;
  int err_total, tests_run, cyc, n;
  pcrc_top #(.WAKE_CYCLES(8)) DUT (.*);
  pcrc_osc_model #(.DLY(20)) u_osc (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .osc_en_i(osc_en_o), .osc_ready_o(osc_ready_i));
  // Free-running processor clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Cut a hang short
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      stop_test;
    end
  end
  task stop_test;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cycles from one peripheral pulse to the next
  task per(output int k);
    k = 0;
    do begin @(negedge clk_sys_i); k++; end while (!pclk_en_o && k < 50);
  endtask
  // Request a ratio, then measure the settled period
  task t_div(input logic [1:0] s, input int p);
    @(negedge clk_sys_i);
    apb_div_sel_i = s;
    apb_div_wr_i = 1'b1;
    n = 0;
    while (apb_div_now_o !== s && n < 20) begin @(negedge clk_sys_i); n++; end
    apb_div_wr_i = 1'b0;
    per(n);
    per(n);
    `CHK(n, p)
  endtask
  task t_reset;
    `CHK(apb_div_now_o, 2'h0)
    per(n);
    per(n);
    `CHK(n, 4)
    `CHK(vec_from_sram_o, 1'b0)
  endtask
  task t_gate;
    periph_pwr_i = 16'h00A5;
    per(n);
    `CHK(periph_clk_en_o, 16'h00A5)
    periph_pwr_i = 16'hFFFF;
  endtask
  task t_src;
    @(negedge clk_sys_i) pll_connect_i = 1'b1;
    @(negedge clk_sys_i) `CHK(clk_src_pll_o, 1'b1)
    pll_on_i = 1'b0;
    @(negedge clk_sys_i) `CHK(clk_src_pll_o, 1'b0)
    pll_on_i = 1'b1;
    pll_connect_i = 1'b0;
  endtask
  task t_idle;
    @(negedge clk_sys_i) idle_req_i = 1'b1;
    @(negedge clk_sys_i) idle_req_i = 1'b0;
    `CHK({mode_o, cpu_clk_en_o, mem_clk_en_o, bus_clk_en_o}, 5'h08)
    pll_on_i = 1'b0;
    per(n);
    `CHK(pclk_en_o, 1'b1)
    `CHK(pll_en_o, 1'b1)
    irq_i = 1'b1;
    @(negedge clk_sys_i) irq_i = 1'b0;
    `CHK({mode_o, cpu_clk_en_o}, 3'h1)
  endtask
  task t_pdown;
    @(negedge clk_sys_i) remap_sram_i = 1'b1;
    pdown_req_i = 1'b1;
    @(negedge clk_sys_i) pdown_req_i = 1'b0;
    `CHK(vec_from_sram_o, 1'b1)
    `CHK({mode_o, osc_en_o, pin_hold_o, state_retain_o}, 5'h13)
    irq_i = 1'b1;
    ext_irq_i = 4'h4;
    repeat (3) @(negedge clk_sys_i);
    `CHK(mode_o, 2'h2)
    irq_i = 1'b0;
    ext_wake_en_i = 4'h4;
    @(negedge clk_sys_i) `CHK(mode_o, 2'h3)
    ext_irq_i = 4'h0;
    n = 0;
    while (mode_o !== 2'h0 && n < 60) begin @(negedge clk_sys_i); n++; end
    `CHK(n >= 20 && n < 30, 1'b1)
    `CHK({pin_hold_o, cpu_clk_en_o}, 2'h1)
  endtask
  // Main sequence
  initial begin
    {rst_n_i, remap_sram_i, idle_req_i, pdown_req_i, irq_i} = 5'h00;
    {pll_on_i, pll_connect_i, apb_div_wr_i, apb_div_sel_i} = 5'h00;
    {ext_irq_i, ext_wake_en_i, periph_pwr_i} = 24'h00FFFF;
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_reset;
    t_div(2'h1, 1);
    t_div(2'h2, 2);
    t_div(2'h0, 4);
    t_gate;
    pll_on_i = 1'b1;
    t_src;
    t_idle;
    t_pdown;
    stop_test;
  end
endmodule
bind pcrc_top pcrc_top_chk #(
  .NUM_PERIPH(NUM_PERIPH),
  .NUM_WAKE(NUM_WAKE)
) u_chk (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .idle_req_i(idle_req_i),
  .pdown_req_i(pdown_req_i),
  .irq_i(irq_i),
  .ext_irq_i(ext_irq_i),
  .ext_wake_en_i(ext_wake_en_i),
  .periph_pwr_i(periph_pwr_i),
  .cpu_clk_en_o(cpu_clk_en_o),
  .pclk_en_o(pclk_en_o),
  .periph_clk_en_o(periph_clk_en_o),
  .osc_en_o(osc_en_o),
  .pll_en_o(pll_en_o),
  .pin_hold_o(pin_hold_o),
  .state_retain_o(state_retain_o),
  .apb_div_now_o(apb_div_now_o),
  .mode_o(mode_o)
);
